// [rtl/sol_frame_if.sv]
`timescale 1ns/1ns
interface sol_frame_if;
    logic       frame_start;
    logic       frame_end;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       sck_fall;
    logic       quad;
    logic       on_boundary;

    modport rx (output frame_start, frame_end, byte_valid, byte_data, sck_fall, quad,
                on_boundary);
    modport core (input frame_start, frame_end, byte_valid, byte_data, sck_fall, quad,
                  on_boundary);
endinterface

// [rtl/sol_link_rx.sv]
`timescale 1ns/1ns
module sol_link_rx (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // link pins
    input  wire logic       link_sck,
    input  wire logic       link_cs_n,
    input  wire logic [3:0] link_io_in,
    // configuration
    input  wire logic       quad_mode,
    // framed bytes toward the core
    sol_frame_if.rx         frm
);
    logic       sck_s1, sck_s2, sck_d;
    logic       cs_s1, cs_s2, cs_d;
    logic [3:0] io_s1, io_s2;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic       quad_q, next_quad_q;
    logic       next_start, next_end, next_byte_valid, next_fall;
    logic       sck_rise;

    // two stages on every pin; data and clock stay aligned
    always_ff @(posedge sys_clk) begin
        sck_s1 <= link_sck;
        sck_s2 <= sck_s1;
        cs_s1  <= link_cs_n;
        cs_s2  <= cs_s1;
        io_s1  <= link_io_in;
        io_s2  <= io_s1;
    end

    assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;

    always_comb begin
        next_bit_cnt    = bit_cnt;
        next_shreg      = shreg;
        next_quad_q     = quad_q;
        next_start      = ~cs_s2 & cs_d;
        next_end        = cs_s2 & ~cs_d;
        next_fall       = ~sck_s2 & sck_d & ~cs_s2;
        next_byte_valid = 1'b0;
        if (next_start) begin
            next_bit_cnt = 3'h0;
            next_quad_q  = quad_mode;
        end
        if (sck_rise) begin
            if (next_quad_q) begin
                next_shreg   = {shreg[3:0], io_s2};  // [RL14]
                next_bit_cnt = 3'(bit_cnt + 3'h4);
            end else begin
                next_shreg   = {shreg[6:0], io_s2[0]};  // [RL14]
                next_bit_cnt = 3'(bit_cnt + 3'h1);
            end
            next_byte_valid = (next_bit_cnt == 3'h0);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_d            <= 1'b0;
            cs_d             <= 1'b1;
            bit_cnt          <= 3'h0;
            shreg            <= 8'h00;
            quad_q           <= 1'b0;
            frm.frame_start  <= 1'b0;
            frm.frame_end    <= 1'b0;
            frm.byte_valid   <= 1'b0;
            frm.byte_data    <= 8'h00;
            frm.sck_fall     <= 1'b0;
            frm.on_boundary  <= 1'b1;
        end else begin
            sck_d            <= sck_s2;
            cs_d             <= cs_s2;
            bit_cnt          <= next_bit_cnt;
            shreg            <= next_shreg;
            quad_q           <= next_quad_q;
            frm.frame_start  <= next_start;
            frm.frame_end    <= next_end;
            frm.byte_valid   <= next_byte_valid;
            frm.byte_data    <= next_shreg;
            frm.sck_fall     <= next_fall;
            frm.on_boundary  <= (next_bit_cnt == 3'h0);
        end
    end

    assign frm.quad = quad_q;
endmodule

// [rtl/sol_otp_lock.sv]
// Function
// RL1 - opcode B1h puts the device into the one-time-programmable mode for the 4K-bit region.
// RL2 - in that mode ordinary read and program sequences are steered to the region.
// RL3 - opcode C1h leaves the mode and returns accesses to the main array.
// RL4 - while in the mode, writes to status one, status two and lock status are rejected.
// RL5 - once the region is locked, only reads are accepted and program or erase is ignored.
// RL6 - opcode 2Bh returns the lock status at any time, repeating while clocks continue.
// RL7 - lock bit 0 is a read-only factory-lock indicator.
// RL8 - lock bit 1 is a customer lock set by write-lock; once set nothing changes it again.
// RL9 - while in the mode, every write to the main array is blocked.
// RL10 - parameter bytes 65h to 67h read A2h, D5h and 5Ch.
// RL11 - parameter bytes 68h to 6Ah read 19h, F6h and 1Ch.
// RL12 - parameter bytes 84h and 85h read DAh and 06h.
// RL13 - write-lock needs no write enable and runs only if the frame ends on a byte boundary.
// RL14 - each command is framed by chip select low, opcode on one line or four lines.
// RL15 - lock bits 7 to 2 are reserved, ignore writes and read as don't-care.
`timescale 1ns/1ns
module sol_otp_lock (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // link pins
    input  wire logic       link_sck,
    input  wire logic       link_cs_n,
    input  wire logic [3:0] link_io_in,
    output logic      [3:0] link_io_out,
    output logic      [3:0] link_io_oe,
    // configuration and non-volatile cells
    input  wire logic       quad_mode,
    input  wire logic       factory_lock_nv,
    input  wire logic       customer_lock_nv,
    // toward the array engines
    output logic            otp_mode,
    output logic            main_write_block,
    output logic            otp_write_block,
    output logic            status_write_block,
    output logic      [7:0] cmd_opcode,
    output logic            cmd_valid,
    output logic            cmd_reject,
    output logic            customer_lock_program,
    output logic      [7:0] lock_status,
    // discoverable-parameter lookup
    input  wire logic [7:0] param_addr,
    output logic      [7:0] param_data
);
    sol_frame_if frm ();

    sol_link_rx u_rx (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .link_sck   (link_sck),
        .link_cs_n  (link_cs_n),
        .link_io_in (link_io_in),
        .quad_mode  (quad_mode),
        .frm        (frm)
    );

    logic [7:0] rom_data;

    sol_param_rom u_rom (
        .addr (param_addr),
        .data (rom_data)
    );

    sol_pkg::sol_state_t state, next_state;
    logic       factory_lock, next_factory_lock;
    logic       customer_lock, next_customer_lock;
    logic       nv_loaded, next_nv_loaded;
    logic       next_otp_mode;
    logic [7:0] next_cmd_opcode;
    logic       next_cmd_valid, next_cmd_reject, next_program;
    logic [1:0] byte_cnt, next_byte_cnt;
    logic [7:0] wr_data, next_wr_data;
    logic [7:0] tx_shift, next_tx_shift;
    logic [2:0] tx_cnt, next_tx_cnt;
    logic [3:0] next_io_out, next_io_oe;
    logic [7:0] status_now, tx_src;
    logic       locked;

    assign locked     = factory_lock | customer_lock;
    // reserved bits always read zero
    assign status_now = {sol_pkg::LOCK_RESERVED_VAL, customer_lock, factory_lock};  // [RL15]
    assign tx_src     = (tx_cnt == 3'h0) ? status_now : tx_shift;

    always_comb begin
        next_state         = state;
        next_factory_lock  = factory_lock;
        next_customer_lock = customer_lock;
        next_nv_loaded     = 1'b1;
        next_otp_mode      = otp_mode;
        next_cmd_opcode    = cmd_opcode;
        next_cmd_valid     = 1'b0;
        next_cmd_reject    = 1'b0;
        next_program       = 1'b0;
        next_byte_cnt      = byte_cnt;
        next_wr_data       = wr_data;
        next_tx_shift      = tx_shift;
        next_tx_cnt        = tx_cnt;
        next_io_out        = link_io_out;
        next_io_oe         = link_io_oe;

        // factory bit is only ever taken from its cell, never written
        if (!nv_loaded) begin
            next_factory_lock  = factory_lock_nv;  // [RL7]
            next_customer_lock = customer_lock_nv;
        end

        if (frm.frame_start) begin
            next_state    = sol_pkg::SOL_ST_OPCODE;
            next_byte_cnt = 2'h0;
            next_tx_cnt   = 3'h0;
        end

        if (frm.byte_valid) begin
            next_byte_cnt = (byte_cnt == 2'h3) ? byte_cnt : 2'(byte_cnt + 2'h1);
        end

        unique case (state)
            sol_pkg::SOL_ST_OPCODE: begin
                if (frm.byte_valid) begin
                    next_cmd_opcode = frm.byte_data;
                    next_state      = sol_pkg::SOL_ST_SKIP;
                    if (frm.byte_data == sol_pkg::OP_OTP_ENTER) begin
                        next_otp_mode = 1'b1;  // [RL1]
                    end else if (frm.byte_data == sol_pkg::OP_OTP_EXIT) begin
                        next_otp_mode = 1'b0;  // [RL3]
                    end else if (frm.byte_data == sol_pkg::OP_LOCK_READ) begin
                        next_state = sol_pkg::SOL_ST_LOCK_READ;  // [RL6]
                    end else if (otp_mode && sol_pkg::sol_is_status_write(frm.byte_data)) begin
                        next_cmd_reject = 1'b1;  // [RL4]
                    end else if (frm.byte_data == sol_pkg::OP_LOCK_WRITE) begin
                        // no write-enable latch is consulted here
                        next_state = sol_pkg::SOL_ST_LOCK_WRITE;  // [RL13]
                    end else if (otp_mode && locked
                                 && sol_pkg::sol_is_array_write(frm.byte_data)) begin
                        next_cmd_reject = 1'b1;  // [RL5]
                    end else begin
                        // engines pick the target from otp_mode
                        next_cmd_valid = 1'b1;  // [RL2]
                    end
                end
            end
            sol_pkg::SOL_ST_LOCK_READ: begin
                // status is re-read at each byte start so updates show mid-stream
                if (frm.sck_fall) begin
                    if (frm.quad) begin
                        next_io_out   = tx_src[7:4];  // [RL6]
                        next_io_oe    = sol_pkg::IO_OE_QUAD;
                        next_tx_shift = {tx_src[3:0], 4'h0};
                        next_tx_cnt   = 3'(tx_cnt + 3'h4);
                    end else begin
                        next_io_out   = {2'h0, tx_src[7], 1'b0};  // [RL6]
                        next_io_oe    = sol_pkg::IO_OE_SINGLE;
                        next_tx_shift = {tx_src[6:0], 1'b0};
                        next_tx_cnt   = 3'(tx_cnt + 3'h1);
                    end
                end
            end
            sol_pkg::SOL_ST_LOCK_WRITE: begin
                if (frm.byte_valid && byte_cnt == 2'h1) begin
                    next_wr_data = frm.byte_data;
                end
            end
            sol_pkg::SOL_ST_SKIP: begin
            end
        endcase

        if (frm.frame_end) begin
            next_io_oe = sol_pkg::IO_OE_OFF;
            next_state = sol_pkg::SOL_ST_OPCODE;
            if (state == sol_pkg::SOL_ST_LOCK_WRITE) begin
                // only bit 1 is writable; bits 7..2 and bit 0 are dropped
                if (frm.on_boundary && byte_cnt == sol_pkg::LOCK_WRITE_BYTES
                    && !customer_lock && wr_data[sol_pkg::LOCK_CUSTOMER_BIT]) begin
                    next_customer_lock = 1'b1;  // [RL8] [RL13] [RL15]
                    next_program       = 1'b1;
                end else if (!frm.on_boundary || byte_cnt != sol_pkg::LOCK_WRITE_BYTES) begin
                    next_cmd_reject = 1'b1;  // [RL13]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state                 <= sol_pkg::SOL_ST_OPCODE;
            factory_lock          <= 1'b0;
            customer_lock         <= 1'b0;
            nv_loaded             <= 1'b0;
            otp_mode              <= 1'b0;
            main_write_block      <= 1'b0;
            otp_write_block       <= 1'b0;
            status_write_block    <= 1'b0;
            cmd_opcode            <= 8'h00;
            cmd_valid             <= 1'b0;
            cmd_reject            <= 1'b0;
            customer_lock_program <= 1'b0;
            lock_status           <= sol_pkg::LOCK_STATUS_RESET;
            param_data            <= 8'h00;
            byte_cnt              <= 2'h0;
            wr_data               <= 8'h00;
            tx_shift              <= 8'h00;
            tx_cnt                <= 3'h0;
            link_io_out           <= 4'h0;
            link_io_oe            <= sol_pkg::IO_OE_OFF;
        end else begin
            state                 <= next_state;
            factory_lock          <= next_factory_lock;
            customer_lock         <= next_customer_lock;
            nv_loaded             <= next_nv_loaded;
            otp_mode              <= next_otp_mode;
            main_write_block      <= next_otp_mode;  // [RL9]
            otp_write_block       <= next_otp_mode & (next_factory_lock | next_customer_lock);  // [RL5]
            status_write_block    <= next_otp_mode;  // [RL4]
            cmd_opcode            <= next_cmd_opcode;
            cmd_valid             <= next_cmd_valid;
            cmd_reject            <= next_cmd_reject;
            customer_lock_program <= next_program;
            lock_status           <= {sol_pkg::LOCK_RESERVED_VAL, next_customer_lock,
                                      next_factory_lock};
            param_data            <= rom_data;
            byte_cnt              <= next_byte_cnt;
            wr_data               <= next_wr_data;
            tx_shift              <= next_tx_shift;
            tx_cnt                <= next_tx_cnt;
            link_io_out           <= next_io_out;
            link_io_oe            <= next_io_oe;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    otp_enter_a: assert property (  // [RL1]
        state == sol_pkg::SOL_ST_OPCODE && frm.byte_valid
        && frm.byte_data == sol_pkg::OP_OTP_ENTER |=> otp_mode ##1 main_write_block)
        else $error("mode entry opcode did not set mode");
    otp_exit_a: assert property (  // [RL3]
        state == sol_pkg::SOL_ST_OPCODE && frm.byte_valid
        && frm.byte_data == sol_pkg::OP_OTP_EXIT |=> !otp_mode)
        else $error("mode exit opcode did not clear mode");
    status_reject_a: assert property (  // [RL4]
        state == sol_pkg::SOL_ST_OPCODE && frm.byte_valid && otp_mode
        && sol_pkg::sol_is_status_write(frm.byte_data) |=> cmd_reject && !cmd_valid)
        else $error("status write accepted in otp mode");
    locked_write_a: assert property (  // [RL5]
        state == sol_pkg::SOL_ST_OPCODE && frm.byte_valid && otp_mode && locked
        && sol_pkg::sol_is_array_write(frm.byte_data) |=> cmd_reject && !cmd_valid)
        else $error("write accepted on locked region");
    read_drive_a: assert property (  // [RL6]
        state == sol_pkg::SOL_ST_LOCK_READ && frm.sck_fall && !frm.quad && !frm.frame_end
        |=> link_io_oe == sol_pkg::IO_OE_SINGLE)
        else $error("lock read did not drive output line");
    factory_fixed_a: assert property (  // [RL7]
        nv_loaded |=> $stable(factory_lock))
        else $error("factory lock bit changed");
    customer_sticky_a: assert property (  // [RL8]
        nv_loaded && customer_lock |=> customer_lock && !customer_lock_program)
        else $error("customer lock cleared or reprogrammed");
    main_block_a: assert property (  // [RL9]
        $rose(otp_mode) |-> ##1 main_write_block && otp_mode)
        else $error("main array writes not blocked in otp mode");
    param_byte_a: assert property (  // [RL10]
        param_addr == sol_pkg::PARAM_ADDR_65 |=> param_data == sol_pkg::PARAM_VAL_65)
        else $error("parameter byte 65h wrong");
    partial_write_a: assert property (  // [RL13]
        frm.frame_end && state == sol_pkg::SOL_ST_LOCK_WRITE && !frm.on_boundary
        |=> !customer_lock_program && cmd_reject)
        else $error("off-boundary write-lock executed");
    reserved_zero_a: assert property (  // [RL15]
        lock_status[7:2] == sol_pkg::LOCK_RESERVED_VAL)
        else $error("reserved lock bits not zero");

    param_66_a: assert property (  // [RL10]
        param_addr == sol_pkg::PARAM_ADDR_66 |=> param_data == sol_pkg::PARAM_VAL_66)
        else $error("parameter byte 66h wrong");
    param_67_a: assert property (  // [RL10]
        param_addr == sol_pkg::PARAM_ADDR_67 |=> param_data == sol_pkg::PARAM_VAL_67)
        else $error("parameter byte 67h wrong");

    param_68_a: assert property (  // [RL11]
        param_addr == sol_pkg::PARAM_ADDR_68 |=> param_data == sol_pkg::PARAM_VAL_68)
        else $error("parameter byte 68h wrong");
    param_69_a: assert property (  // [RL11]
        param_addr == sol_pkg::PARAM_ADDR_69 |=> param_data == sol_pkg::PARAM_VAL_69)
        else $error("parameter byte 69h wrong");
    param_6a_a: assert property (  // [RL11]
        param_addr == sol_pkg::PARAM_ADDR_6A |=> param_data == sol_pkg::PARAM_VAL_6A)
        else $error("parameter byte 6Ah wrong");

    param_84_a: assert property (  // [RL12]
        param_addr == sol_pkg::PARAM_ADDR_84 |=> param_data == sol_pkg::PARAM_VAL_84)
        else $error("parameter byte 84h wrong");
    param_85_a: assert property (  // [RL12]
        param_addr == sol_pkg::PARAM_ADDR_85 |=> param_data == sol_pkg::PARAM_VAL_85)
        else $error("parameter byte 85h wrong");

    pulse_excl_a: assert property (  // [RL2]
        cmd_valid |-> !cmd_reject)
        else $error("opcode both handed on and rejected");
    oe_release_a: assert property (  // [RL14]
        frm.frame_end |=> link_io_oe == sol_pkg::IO_OE_OFF)
        else $error("data lines still driven after frame");
    read_stays_a: assert property (  // [RL6]
        state == sol_pkg::SOL_ST_LOCK_READ && !frm.frame_end && !frm.frame_start
        |=> state == sol_pkg::SOL_ST_LOCK_READ)
        else $error("lock read stopped inside frame");
    exit_unblock_a: assert property (  // [RL3]
        $fell(otp_mode) |-> !main_write_block && !status_write_block)
        else $error("write blocks held after mode exit");
endmodule

// [rtl/sol_param_rom.sv]
`timescale 1ns/1ns
module sol_param_rom (
    // lookup
    input  wire logic [7:0] addr,
    output logic      [7:0] data
);
    always_comb begin
        unique case (addr)
            sol_pkg::PARAM_ADDR_65: data = sol_pkg::PARAM_VAL_65;  // [RL10]
            sol_pkg::PARAM_ADDR_66: data = sol_pkg::PARAM_VAL_66;  // [RL10]
            sol_pkg::PARAM_ADDR_67: data = sol_pkg::PARAM_VAL_67;  // [RL10]
            sol_pkg::PARAM_ADDR_68: data = sol_pkg::PARAM_VAL_68;  // [RL11]
            sol_pkg::PARAM_ADDR_69: data = sol_pkg::PARAM_VAL_69;  // [RL11]
            sol_pkg::PARAM_ADDR_6A: data = sol_pkg::PARAM_VAL_6A;  // [RL11]
            sol_pkg::PARAM_ADDR_84: data = sol_pkg::PARAM_VAL_84;  // [RL12]
            sol_pkg::PARAM_ADDR_85: data = sol_pkg::PARAM_VAL_85;  // [RL12]
            // other bytes belong to tables outside this block
            default:                data = sol_pkg::PARAM_VAL_RSV;
        endcase
    end
endmodule

// [rtl/sol_pkg.sv]
package sol_pkg;
    // opcodes handled or screened by the lock logic
    localparam logic [7:0] OP_OTP_ENTER   = 8'hb1;
    localparam logic [7:0] OP_OTP_EXIT    = 8'hc1;
    localparam logic [7:0] OP_LOCK_READ   = 8'h2b;
    localparam logic [7:0] OP_LOCK_WRITE  = 8'h2f;
    localparam logic [7:0] OP_SR1_WRITE   = 8'h01;
    localparam logic [7:0] OP_SR2_WRITE   = 8'h31;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG   = 8'h32;
    localparam logic [7:0] OP_ERASE_4K    = 8'h20;
    localparam logic [7:0] OP_ERASE_32K   = 8'h52;
    localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
    localparam logic [7:0] OP_ERASE_CHIP  = 8'hc7;
    localparam logic [7:0] OP_ERASE_CHIP2 = 8'h60;

    // one-time-programmable region size in bits
    localparam int OTP_REGION_BITS = 4096;

    // lock-status register layout
    localparam int              LOCK_FACTORY_BIT  = 0;
    localparam int              LOCK_CUSTOMER_BIT = 1;
    localparam logic [7:0]      LOCK_STATUS_RESET = 8'h00;
    localparam logic [5:0]      LOCK_RESERVED_VAL = 6'h00;

    // write-lock frame: opcode plus one data byte
    localparam logic [1:0] LOCK_WRITE_BYTES = 2'h2;

    // discoverable-parameter bytes
    localparam logic [7:0] PARAM_ADDR_65 = 8'h65;
    localparam logic [7:0] PARAM_ADDR_66 = 8'h66;
    localparam logic [7:0] PARAM_ADDR_67 = 8'h67;
    localparam logic [7:0] PARAM_ADDR_68 = 8'h68;
    localparam logic [7:0] PARAM_ADDR_69 = 8'h69;
    localparam logic [7:0] PARAM_ADDR_6A = 8'h6a;
    localparam logic [7:0] PARAM_ADDR_84 = 8'h84;
    localparam logic [7:0] PARAM_ADDR_85 = 8'h85;
    localparam logic [7:0] PARAM_VAL_65  = 8'ha2;
    localparam logic [7:0] PARAM_VAL_66  = 8'hd5;
    localparam logic [7:0] PARAM_VAL_67  = 8'h5c;
    localparam logic [7:0] PARAM_VAL_68  = 8'h19;
    localparam logic [7:0] PARAM_VAL_69  = 8'hf6;
    localparam logic [7:0] PARAM_VAL_6A  = 8'h1c;
    localparam logic [7:0] PARAM_VAL_84  = 8'hda;
    localparam logic [7:0] PARAM_VAL_85  = 8'h06;
    localparam logic [7:0] PARAM_VAL_RSV = 8'hff;

    // link pin usage
    localparam logic [3:0] IO_OE_SINGLE = 4'h2;
    localparam logic [3:0] IO_OE_QUAD   = 4'hf;
    localparam logic [3:0] IO_OE_OFF    = 4'h0;

    typedef enum logic [1:0] {
        SOL_ST_OPCODE     = 2'b00,
        SOL_ST_LOCK_READ  = 2'b01,
        SOL_ST_LOCK_WRITE = 2'b10,
        SOL_ST_SKIP       = 2'b11
    } sol_state_t;

    function automatic logic sol_is_status_write(input logic [7:0] op);
        return (op == OP_SR1_WRITE) || (op == OP_SR2_WRITE) || (op == OP_LOCK_WRITE);
    endfunction

    function automatic logic sol_is_array_write(input logic [7:0] op);
        return (op == OP_PAGE_PROG) || (op == OP_QUAD_PROG) || (op == OP_ERASE_4K)
            || (op == OP_ERASE_32K) || (op == OP_ERASE_64K) || (op == OP_ERASE_CHIP)
            || (op == OP_ERASE_CHIP2);
    endfunction
endpackage

// [verif/sol_host_model.sv]
`timescale 1ns/1ns
module sol_host_model (
    // clock
    input  wire logic       sys_clk,
    // link pins
    output logic            link_sck,
    output logic            link_cs_n,
    output logic      [3:0] link_io_in,
    input  wire logic [3:0] link_io_out
);
    initial begin
        link_sck = 1'b0;
        link_cs_n = 1'b1;
        link_io_in = 4'h0;
    end

    // mode 0 frame, msb first from the top of d; reply sampled late in the high
    // phase since the device answers four cycles after each fall
    task automatic frame(input logic [23:0] d, input int n, input logic quad,
                         output logic [15:0] rd);
        rd = 16'h0;
        link_cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < (quad ? n / 4 : n); i++) begin
            link_io_in <= quad ? d[23:20] : {3'h0, d[23]};
            d = quad ? d << 4 : d << 1;
            repeat (4) @(posedge sys_clk);
            link_sck <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rd = {rd[14:0], link_io_out[1]};
            link_sck <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        link_cs_n <= 1'b1;
        // released lines must not keep the last value
        link_io_in <= ~link_io_in;
        repeat (10) @(posedge sys_clk);
    endtask
endmodule

// [verif/tb_secured_otp_and_lock_control.sv]
`timescale 1ns/1ns
module tb_secured_otp_and_lock_control;
    logic        sys_clk, rst_n, link_sck, link_cs_n, quad_mode;
    logic        factory_lock_nv, customer_lock_nv, otp_mode, main_write_block;
    logic        otp_write_block, status_write_block, cmd_valid, cmd_reject;
    logic        customer_lock_program;
    logic [3:0]  link_io_in, link_io_out, link_io_oe;
    logic [7:0]  cmd_opcode, lock_status, param_addr, param_data;
    logic [15:0] rd;
    logic [7:0]  pa [9] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h84, 8'h85, 8'h86};
    logic [7:0]  pv [9] = '{8'ha2, 8'hd5, 8'h5c, 8'h19, 8'hf6, 8'h1c, 8'hda, 8'h06, 8'hff};
    logic [7:0]  sw [3] = '{8'h01, 8'h31, 8'h2f};
    int          err_count = 0;
    int          samples_checked = 0;
    int          nv = 0, nr = 0, np = 0, ev = 0, er = 0, ep = 0, cycles = 0;

    sol_otp_lock i_dut (.sys_clk, .rst_n, .link_sck, .link_cs_n, .link_io_in, .link_io_out,
        .link_io_oe, .quad_mode, .factory_lock_nv, .customer_lock_nv, .otp_mode,
        .main_write_block, .otp_write_block, .status_write_block, .cmd_opcode, .cmd_valid,
        .cmd_reject, .customer_lock_program, .lock_status, .param_addr, .param_data);
    sol_host_model i_host (.sys_clk, .link_sck, .link_cs_n, .link_io_in, .link_io_out);

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one frame, then the pulse tallies must have grown by exactly dv, dr, dp
    task automatic cmd(input logic [23:0] d, input int n, input int dv, input int dr,
                       input int dp);
        i_host.frame(d, n, quad_mode, rd);
        ev += dv;
        er += dr;
        ep += dp;
        check8(8'(nv), 8'(ev), "valid pulses");
        check8(8'(nr), 8'(er), "reject pulses");
        check8(8'(np), 8'(ep), "lock program pulses");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        nv <= nv + int'(cmd_valid === 1'b1);
        nr <= nr + int'(cmd_reject === 1'b1);
        np <= np + int'(customer_lock_program === 1'b1);
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        quad_mode = 1'b0;
        factory_lock_nv = 1'b0;
        customer_lock_nv = 1'b0;
        param_addr = 8'h00;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check8(lock_status, 8'h00, "lock after reset");
        foreach (pa[i]) begin
            param_addr <= pa[i];
            repeat (2) @(posedge sys_clk);
            check8(param_data, pv[i], "param byte");
        end
        cmd({8'h2b, 16'h0}, 24, 0, 0, 0);
        check8(rd[15:8], 8'h00, "lock read");
        check8(8'(link_io_oe), 8'h00, "output released");
        cmd({8'h02, 16'h0}, 8, 1, 0, 0);
        check8(cmd_opcode, 8'h02, "opcode handed on");
        cmd({8'hb1, 16'h0}, 8, 0, 0, 0);
        check8({otp_mode, main_write_block, status_write_block}, 8'h07, "otp blocks");
        foreach (sw[i])
            cmd({sw[i], 8'h02, 8'h0}, 16, 0, 1, 0);
        cmd({8'h02, 16'h0}, 8, 1, 0, 0);
        check8(otp_write_block, 8'h00, "unlocked otp write");
        cmd({8'hc1, 16'h0}, 8, 0, 0, 0);
        check8({otp_mode, main_write_block}, 8'h00, "otp exit");
        cmd({8'h2f, 8'hfe, 8'h0}, 15, 0, 1, 0);
        cmd({8'h2f, 8'hfe, 8'h0}, 16, 0, 0, 1);
        check8(lock_status, 8'h02, "customer lock");
        customer_lock_nv <= 1'b1;
        cmd({8'h2f, 8'hfe, 8'h0}, 16, 0, 0, 0);
        cmd({8'hb1, 16'h0}, 8, 0, 0, 0);
        cmd({8'h02, 16'h0}, 8, 0, 1, 0);
        check8(otp_write_block, 8'h01, "locked otp write");
        cmd({8'h2b, 16'h0}, 24, 0, 0, 0);
        check8(rd[15:8], 8'h02, "lock read first");
        check8(rd[7:0], 8'h02, "lock read repeat");
        quad_mode <= 1'b1;
        // the host copies quad_mode at call time, so let it settle first
        @(posedge sys_clk);
        cmd({8'hc1, 16'h0}, 8, 0, 0, 0);
        check8(otp_mode, 8'h00, "quad exit");
        check8(cmd_opcode, 8'hc1, "quad opcode");
        quad_mode <= 1'b0;
        rst_n <= 1'b0;
        factory_lock_nv <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check8(lock_status, 8'h03, "factory lock");
        print_verdict();
    end
endmodule
